// ==== hw/sdo_top.sv ====
`include "sdo_cfg.svh"
module sdo_top (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // AXI4-Lite slave
  input  wire logic [11:0]           s_awaddr_i,
  input  wire logic                  s_awvalid_i,
  output logic                       s_awready_o,
  input  wire sdo_pkg::sdo_word_t    s_wdata_i,
  input  wire logic [3:0]            s_wstrb_i,
  input  wire logic                  s_wvalid_i,
  output logic                       s_wready_o,
  output logic [1:0]                 s_bresp_o,
  output logic                       s_bvalid_o,
  input  wire logic                  s_bready_i,
  input  wire logic [11:0]           s_araddr_i,
  input  wire logic                  s_arvalid_i,
  output logic                       s_arready_o,
  output sdo_pkg::sdo_word_t         s_rdata_o,
  output logic [1:0]                 s_rresp_o,
  output logic                       s_rvalid_o,
  input  wire logic                  s_rready_i,
  // Drive status, same clock domain
  input  wire logic                  ready_to_enable_i,
  input  wire logic                  fault_i,
  input  wire logic                  position_mode_i,
  input  wire logic                  torque_mode_i,
  input  wire logic                  enabled_i,
  input  wire logic                  shaft_held_i,
  input  wire logic                  brake_release_i,
  input  wire logic                  pos_limit_i,
  input  wire logic                  home_found_i,
  input  wire logic [2:0]            seg_reached_i,
  input  wire logic                  ms_tick_i,
  input  wire logic signed [31:0]    pos_error_i,
  input  wire logic signed [31:0]    velocity_i,
  input  wire logic signed [31:0]    speed_error_i,
  input  wire logic signed [31:0]    torque_i,
  // Encoder index pin, asynchronous
  input  wire logic                  enc_index_i,
  output logic [`SDO_NOUT-1:0]       dout_o,
  output logic                       irq_o
);
  import sdo_pkg::*;

  // ************************************************************
  // Register bus
  // ************************************************************
  logic [31:0]          fsel0_reg, fsel1_reg;
  logic [`SDO_NOUT-1:0] pol_reg, simen_reg, simval_reg;
  logic [31:0]          poswin_reg, zvwin_reg, spwin_reg, maxspd_reg, tqref_reg;
  logic [`SDO_TMR_W-1:0] postim_reg, zvtim_reg, tqtim_reg;
  logic [`SDO_NOUT-1:0] irqst_reg, irqmsk_reg;
  logic [`SDO_NOUT-1:0] eff_reg;
  logic [11:0]          awaddr_reg;
  logic                 aw_have_reg, w_have_reg;
  sdo_word_t            wdata_reg;
  logic [3:0]           wstrb_reg;
  logic                 wr_fire;
  logic                 wr_ok;
  sdo_rd_e              rd_state_reg;

  assign s_awready_o = !aw_have_reg && !s_bvalid_o;
  assign s_wready_o  = !w_have_reg && !s_bvalid_o;
  assign wr_fire     = aw_have_reg && w_have_reg && !s_bvalid_o;
  assign s_arready_o = (rd_state_reg == SDO_RD_IDLE);

  // Address and data taken in either order, then one response
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= 12'h000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      s_bvalid_o  <= 1'b0;
      s_bresp_o   <= 2'b00;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_wdata_i;
        wstrb_reg  <= s_wstrb_i;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        s_bvalid_o  <= 1'b1;
        s_bresp_o   <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_bvalid_o && s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
    end
  end

  // Writable offsets; anything else answers SLVERR
  always_comb begin
    case (awaddr_reg)
      `SDO_A_FSEL0, `SDO_A_FSEL1, `SDO_A_POL, `SDO_A_SIMEN, `SDO_A_SIMVAL,
      `SDO_A_POSWIN, `SDO_A_POSTIM, `SDO_A_ZVWIN, `SDO_A_ZVTIM, `SDO_A_SPWIN,
      `SDO_A_MAXSPD, `SDO_A_TQREF, `SDO_A_TQTIM, `SDO_A_IRQST,
      `SDO_A_IRQMSK: wr_ok = 1'b1;
      default:       wr_ok = 1'b0;
    endcase
  end

  // Byte-lane merge of a write into an old word
  function automatic sdo_word_t merge(input sdo_word_t old_v, input sdo_word_t new_v,
                                      input logic [3:0] be);
    sdo_word_t r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Configuration registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fsel0_reg  <= `SDO_FSEL_RST;
      fsel1_reg  <= `SDO_FSEL_RST;
      pol_reg    <= `SDO_POL_RST;
      simen_reg  <= 8'h00;
      simval_reg <= 8'h00;
      poswin_reg <= 32'h0000_0000;
      zvwin_reg  <= 32'h0000_0000;
      spwin_reg  <= 32'h0000_0000;
      maxspd_reg <= 32'h0000_0000;
      tqref_reg  <= 32'h0000_0000;
      postim_reg <= 16'h0000;
      zvtim_reg  <= 16'h0000;
      tqtim_reg  <= 16'h0000;
      irqmsk_reg <= 8'h00;
    end else if (wr_fire) begin
      case (awaddr_reg)
        `SDO_A_FSEL0:  fsel0_reg  <= merge(fsel0_reg, wdata_reg, wstrb_reg);
        `SDO_A_FSEL1:  fsel1_reg  <= merge(fsel1_reg, wdata_reg, wstrb_reg);
        `SDO_A_POL:    if (wstrb_reg[0]) pol_reg <= wdata_reg[7:0];
        `SDO_A_SIMEN:  if (wstrb_reg[0]) simen_reg <= wdata_reg[7:0];
        `SDO_A_SIMVAL: if (wstrb_reg[0]) simval_reg <= wdata_reg[7:0];
        `SDO_A_POSWIN: poswin_reg <= merge(poswin_reg, wdata_reg, wstrb_reg);
        `SDO_A_ZVWIN:  zvwin_reg  <= merge(zvwin_reg, wdata_reg, wstrb_reg);
        `SDO_A_SPWIN:  spwin_reg  <= merge(spwin_reg, wdata_reg, wstrb_reg);
        `SDO_A_MAXSPD: maxspd_reg <= merge(maxspd_reg, wdata_reg, wstrb_reg);
        `SDO_A_TQREF:  tqref_reg  <= merge(tqref_reg, wdata_reg, wstrb_reg);
        `SDO_A_POSTIM: postim_reg <= 16'(merge({16'h0000, postim_reg}, wdata_reg, wstrb_reg));
        `SDO_A_ZVTIM:  zvtim_reg  <= 16'(merge({16'h0000, zvtim_reg}, wdata_reg, wstrb_reg));
        `SDO_A_TQTIM:  tqtim_reg  <= 16'(merge({16'h0000, tqtim_reg}, wdata_reg, wstrb_reg));
        `SDO_A_IRQMSK: if (wstrb_reg[0]) irqmsk_reg <= wdata_reg[7:0];
        default: ;
      endcase
    end
  end

  // Read channel, one cycle after the address is taken
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_state_reg <= SDO_RD_IDLE;
      s_rdata_o    <= 32'h0000_0000;
      s_rresp_o    <= 2'b00;
    end else begin
      case (rd_state_reg)
        SDO_RD_IDLE: begin
          if (s_arvalid_i) begin
            rd_state_reg <= SDO_RD_RESP;
            s_rresp_o    <= 2'b00;
            case (s_araddr_i)
              `SDO_A_FSEL0:  s_rdata_o <= fsel0_reg;
              `SDO_A_FSEL1:  s_rdata_o <= fsel1_reg;
              `SDO_A_POL:    s_rdata_o <= {24'h00_0000, pol_reg};
              `SDO_A_SIMEN:  s_rdata_o <= {24'h00_0000, simen_reg};
              `SDO_A_SIMVAL: s_rdata_o <= {24'h00_0000, simval_reg};
              `SDO_A_EFF:    s_rdata_o <= {24'h00_0000, eff_reg};
              `SDO_A_RAW:    s_rdata_o <= {24'h00_0000, dout_o};
              `SDO_A_POSWIN: s_rdata_o <= poswin_reg;
              `SDO_A_POSTIM: s_rdata_o <= {16'h0000, postim_reg};
              `SDO_A_ZVWIN:  s_rdata_o <= zvwin_reg;
              `SDO_A_ZVTIM:  s_rdata_o <= {16'h0000, zvtim_reg};
              `SDO_A_SPWIN:  s_rdata_o <= spwin_reg;
              `SDO_A_MAXSPD: s_rdata_o <= maxspd_reg;
              `SDO_A_TQREF:  s_rdata_o <= tqref_reg;
              `SDO_A_TQTIM:  s_rdata_o <= {16'h0000, tqtim_reg};
              `SDO_A_IRQST:  s_rdata_o <= {24'h00_0000, irqst_reg};
              `SDO_A_IRQMSK: s_rdata_o <= {24'h00_0000, irqmsk_reg};
              default: begin
                s_rdata_o <= 32'h0000_0000;
                s_rresp_o <= 2'b10;
              end
            endcase
          end
        end
        SDO_RD_RESP: begin
          if (s_rready_i) begin
            rd_state_reg <= SDO_RD_IDLE;
          end
        end
        default: rd_state_reg <= SDO_RD_IDLE;
      endcase
    end
  end
  assign s_rvalid_o = (rd_state_reg == SDO_RD_RESP);

  // ************************************************************
  // Status functions
  // ************************************************************
  logic [1:0]  idx_sync_reg;
  logic        idx_prev_reg;
  logic        idx_pulse;
  logic [31:0] abs_pos, abs_vel, abs_spe, abs_tq;
  logic        pos_in, zv_in, tq_in;
  logic [`SDO_TMR_W-1:0] pos_cnt_reg, zv_cnt_reg, tq_cnt_reg;
  logic        posr_reg, zspd_reg, tqlim_reg;
  logic [15:0] func_vec;

  // Index pin is asynchronous; second stage feeds the edge detector
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx_sync_reg <= 2'b00;
      idx_prev_reg <= 1'b0;
    end else begin
      idx_sync_reg <= {idx_sync_reg[0], enc_index_i};
      idx_prev_reg <= idx_sync_reg[1];
    end
  end
  assign idx_pulse = idx_sync_reg[1] && !idx_prev_reg;

  assign abs_pos = pos_error_i[31] ? 32'(-pos_error_i) : pos_error_i;
  assign abs_vel = velocity_i[31] ? 32'(-velocity_i) : velocity_i;
  assign abs_spe = speed_error_i[31] ? 32'(-speed_error_i) : speed_error_i;
  assign abs_tq  = torque_i[31] ? 32'(-torque_i) : torque_i;
  assign pos_in  = position_mode_i && (abs_pos < poswin_reg);
  assign zv_in   = (abs_vel <= zvwin_reg);
  // Zero reference switches the torque detector off entirely
  assign tq_in   = (tqref_reg != 32'h0000_0000) && (abs_tq >= tqref_reg);

  // Dwell timers count ms ticks; saturating so long dwells stay asserted
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_cnt_reg <= 16'h0000;
      zv_cnt_reg  <= 16'h0000;
      tq_cnt_reg  <= 16'h0000;
    end else begin
      if (!pos_in) pos_cnt_reg <= 16'h0000;
      else if (ms_tick_i && pos_cnt_reg != 16'hFFFF) pos_cnt_reg <= pos_cnt_reg + 16'h0001;
      if (!zv_in) zv_cnt_reg <= 16'h0000;
      else if (ms_tick_i && zv_cnt_reg != 16'hFFFF) zv_cnt_reg <= zv_cnt_reg + 16'h0001;
      if (!tq_in) tq_cnt_reg <= 16'h0000;
      else if (ms_tick_i && tq_cnt_reg != 16'hFFFF) tq_cnt_reg <= tq_cnt_reg + 16'h0001;
    end
  end

  // Reached flags; torque needs strictly longer than its filter time
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      posr_reg  <= 1'b0;
      zspd_reg  <= 1'b0;
      tqlim_reg <= 1'b0;
    end else begin
      posr_reg  <= pos_in && (pos_cnt_reg >= postim_reg);
      zspd_reg  <= zv_in && (zv_cnt_reg >= zvtim_reg);
      tqlim_reg <= tq_in && (tq_cnt_reg > tqtim_reg);
    end
  end

  always_comb begin
    func_vec             = 16'h0000;
    func_vec[SDO_F_READY] = ready_to_enable_i;
    func_vec[SDO_F_ERROR] = fault_i;
    func_vec[SDO_F_POSR]  = posr_reg;
    func_vec[SDO_F_ZSPD]  = zspd_reg;
    func_vec[SDO_F_BRAKE] = brake_release_i;
    func_vec[SDO_F_SPDR]  = abs_spe < spwin_reg;
    func_vec[SDO_F_INDEX] = idx_pulse;
    func_vec[SDO_F_SPLIM] = torque_mode_i && (abs_vel >= maxspd_reg);
    func_vec[SDO_F_LOCK]  = enabled_i && shaft_held_i;
    func_vec[SDO_F_PLIM]  = pos_limit_i;
    func_vec[SDO_F_HOME]  = home_found_i;
    func_vec[SDO_F_MF0]   = seg_reached_i[0];
    func_vec[SDO_F_MF1]   = seg_reached_i[1];
    func_vec[SDO_F_MF2]   = seg_reached_i[2];
    func_vec[SDO_F_TQLIM] = tqlim_reg;
  end

  // ************************************************************
  // Output mapping
  // ************************************************************
  logic [`SDO_NOUT-1:0] eff_next, pin_next;
  genvar g;
  generate
    for (g = 0; g < `SDO_NOUT; g++) begin : g_out
      logic [3:0] sel;
      // Split by generate so no branch ever slices outside its select word
      if (g < 4) begin : g_lo
        assign sel = fsel0_reg[8*g +: 4];
      end else begin : g_hi
        assign sel = fsel1_reg[8*(g-4) +: 4];
      end
      // Simulation forces the logical state; polarity then maps it to the pin
      assign eff_next[g] = simen_reg[g] ? simval_reg[g] : func_vec[sel];
      assign pin_next[g] = pol_reg[g] ? !eff_next[g] : eff_next[g];
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eff_reg <= 8'h00;
      dout_o  <= 8'h00;
    end else begin
      eff_reg <= eff_next;
      dout_o  <= pin_next;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  // Rising effective output sets a bit; set beats a write-one clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irqst_reg <= 8'h00;
    end else begin
      irqst_reg <= (irqst_reg & ~((wr_fire && awaddr_reg == `SDO_A_IRQST && wstrb_reg[0])
                                  ? wdata_reg[7:0] : 8'h00)) | (eff_next & ~eff_reg);
    end
  end
  assign irq_o = |(irqst_reg & irqmsk_reg);

  // ************************************************************
  // Assertions
  // ************************************************************
  // Pin follows the effective state through the polarity of the cycle before
  pin_polarity_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    1'b1 |=> dout_o == (eff_reg ^ $past(pol_reg)))
    else $error("pin differs from polarity map");
  sim_override_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    simen_reg[0] |=> eff_reg[0] == $past(simval_reg[0]))
    else $error("sim override lost");
  eff_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!simen_reg[0] && fsel0_reg[3:0] == 4'h0) |=> eff_reg[0] == $past(ready_to_enable_i))
    else $error("effective state wrong");
  // Read-back words carry the state of the cycle in which the address was taken
  eff_readback_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_arvalid_i && s_arready_o && s_araddr_i == `SDO_A_EFF)
    |=> s_rdata_o[7:0] == $past(eff_reg))
    else $error("effective readback wrong");
  raw_readback_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_arvalid_i && s_arready_o && s_araddr_i == `SDO_A_RAW)
    |=> s_rdata_o[7:0] == $past(dout_o))
    else $error("raw readback differs from pin");
  fault_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!simen_reg[0] && fsel0_reg[3:0] == 4'h1) |=> eff_reg[0] == $past(fault_i))
    else $error("error function not mapped");
  brake_map_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!simen_reg[0] && fsel0_reg[3:0] == 4'h4) |=> eff_reg[0] == $past(brake_release_i))
    else $error("brake function not mapped");
  spd_reach_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!simen_reg[0] && fsel0_reg[3:0] == 4'h5) |=> eff_reg[0] == $past(abs_spe < spwin_reg))
    else $error("speed reached wrong");
  tq_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tqref_reg == 32'h0000_0000 |=> !tqlim_reg)
    else $error("torque limit while disabled");
  tq_dwell_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tqlim_reg |-> $past(tq_in) && $past(tq_cnt_reg) > $past(tqtim_reg))
    else $error("torque limit early");
  pos_dwell_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    posr_reg |-> $past(pos_in) && $past(pos_cnt_reg) >= $past(postim_reg))
    else $error("position reached early");
  zv_dwell_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    zspd_reg |-> $past(zv_in) && $past(zv_cnt_reg) >= $past(zvtim_reg))
    else $error("zero speed early");
  idx_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    idx_pulse |=> !idx_pulse)
    else $error("index pulse too long");
  // A clear that meets a new event must lose, or the event is missed
  irq_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_next[0] && !eff_reg[0]) |=> irqst_reg[0])
    else $error("status event lost to clear");
  cov_posr_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(posr_reg));
  cov_tq_c:   cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(tqlim_reg));
  cov_irq_c:  cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(irq_o));
  cov_sim_c:  cover property (@(posedge clk_i) disable iff (!rst_n_i) simen_reg[0] && pol_reg[0]);
endmodule : sdo_top

// ==== shared/sdo_cfg.svh ====
`ifndef SDO_CFG_SVH
`define SDO_CFG_SVH
`define SDO_NOUT        8
`define SDO_FSEL_W      4
`define SDO_TMR_W       16
`define SDO_CLK_MHZ     100
`define SDO_MS_CYC      (`SDO_CLK_MHZ * 1000)
// Register byte offsets
`define SDO_A_FSEL0     12'h000
`define SDO_A_FSEL1     12'h004
`define SDO_A_POL       12'h008
`define SDO_A_SIMEN     12'h00C
`define SDO_A_SIMVAL    12'h010
`define SDO_A_EFF       12'h014
`define SDO_A_RAW       12'h018
`define SDO_A_POSWIN    12'h01C
`define SDO_A_POSTIM    12'h020
`define SDO_A_ZVWIN     12'h024
`define SDO_A_ZVTIM     12'h028
`define SDO_A_SPWIN     12'h02C
`define SDO_A_MAXSPD    12'h030
`define SDO_A_TQREF     12'h034
`define SDO_A_TQTIM     12'h038
`define SDO_A_IRQST     12'h03C
`define SDO_A_IRQMSK    12'h040
`define SDO_POL_RST     8'h00
`define SDO_FSEL_RST    32'hFFFF_FFFF
`endif

// ==== shared/sdo_pkg.sv ====
package sdo_pkg;
  typedef enum logic [3:0] {
    SDO_F_READY  = 4'h0,
    SDO_F_ERROR  = 4'h1,
    SDO_F_POSR   = 4'h2,
    SDO_F_ZSPD   = 4'h3,
    SDO_F_BRAKE  = 4'h4,
    SDO_F_SPDR   = 4'h5,
    SDO_F_INDEX  = 4'h6,
    SDO_F_SPLIM  = 4'h7,
    SDO_F_LOCK   = 4'h8,
    SDO_F_PLIM   = 4'h9,
    SDO_F_HOME   = 4'hA,
    SDO_F_MF0    = 4'hB,
    SDO_F_MF1    = 4'hC,
    SDO_F_MF2    = 4'hD,
    SDO_F_TQLIM  = 4'hE,
    SDO_F_OFF    = 4'hF
  } sdo_func_e;
  typedef enum logic [1:0] {
    SDO_RD_IDLE = 2'b00,
    SDO_RD_RESP = 2'b01
  } sdo_rd_e;
  typedef logic [31:0] sdo_word_t;
endpackage : sdo_pkg

// ==== verification/sdo_relay_model.sv ====
module sdo_relay_model #(
  parameter int DLY = 4
) (
  input  wire logic clk_i,
  input  wire logic coil_i,
  output logic      contact_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Relay read by the far side
  // ********
  int cnt = 0;
  // Contact pulls in only after DLY+1 steady cycles, so a glitch on the pin is not seen
  always_ff @(posedge clk_i) begin
    cnt       <= coil_i ? ((cnt < DLY) ? cnt + 1 : cnt) : 0;
    contact_o <= coil_i && (cnt >= DLY);
  end
endmodule : sdo_relay_model

// ==== verification/servo_digital_output_mapping_tb.sv ====
`include "sdo_cfg.svh"
module servo_digital_output_mapping_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sdo_pkg::*;
  // ********
  // Signals and table
  // ********
  logic clk_i, rst_n_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, irq_o, contact;
  logic ms_tick_i, enc_index_i;
  logic [11:0] s_awaddr_i, s_araddr_i, st;
  logic [3:0] s_wstrb_i;
  logic [1:0] s_bresp_o, s_rresp_o, rsp;
  sdo_word_t s_wdata_i, s_rdata_o, rdv;
  logic signed [31:0] pos_error_i, velocity_i, speed_error_i, torque_i;
  logic [`SDO_NOUT-1:0] dout_o;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int hi;
  typedef struct packed {
    sdo_func_e f; logic [11:0] s; logic signed [31:0] pe, v, se; logic x;
  } sdo_row_s;
  // Function, status levels, position error, velocity, speed error, expected pin
  sdo_row_s rows [25] = '{
    '{SDO_F_READY, 12'h001, 0, 0, 0, 1}, '{SDO_F_READY, 12'h000, 0, 0, 0, 0},
    '{SDO_F_ERROR, 12'h002, 0, 0, 0, 1}, '{SDO_F_ERROR, 12'h000, 0, 0, 0, 0},
    '{SDO_F_POSR, 12'h004, -7, 0, 0, 1}, '{SDO_F_POSR, 12'h004, 8, 0, 0, 0},
    '{SDO_F_POSR, 12'h000, 0, 0, 0, 0}, '{SDO_F_ZSPD, 12'h000, 0, -10, 0, 1},
    '{SDO_F_ZSPD, 12'h000, 0, 11, 0, 0}, '{SDO_F_BRAKE, 12'h040, 0, 0, 0, 1},
    '{SDO_F_BRAKE, 12'h000, 0, 0, 0, 0}, '{SDO_F_SPDR, 12'h000, 0, 0, -4, 1},
    '{SDO_F_SPDR, 12'h000, 0, 0, 5, 0}, '{SDO_F_SPLIM, 12'h008, 0, -50, 0, 1},
    '{SDO_F_SPLIM, 12'h008, 0, 49, 0, 0}, '{SDO_F_SPLIM, 12'h000, 0, 60, 0, 0},
    '{SDO_F_LOCK, 12'h030, 0, 0, 0, 1}, '{SDO_F_LOCK, 12'h010, 0, 0, 0, 0},
    '{SDO_F_PLIM, 12'h080, 0, 0, 0, 1}, '{SDO_F_HOME, 12'h100, 0, 0, 0, 1},
    '{SDO_F_MF0, 12'h200, 0, 0, 0, 1}, '{SDO_F_MF1, 12'h400, 0, 0, 0, 1},
    '{SDO_F_MF2, 12'h800, 0, 0, 0, 1}, '{SDO_F_MF1, 12'h200, 0, 0, 0, 0},
    '{SDO_F_OFF, 12'hFFF, 0, 0, 0, 0}};

  sdo_top DUT (.clk_i, .rst_n_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i,
    .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i,
    .s_araddr_i, .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o,
    .s_rready_i, .ready_to_enable_i(st[0]), .fault_i(st[1]), .position_mode_i(st[2]),
    .torque_mode_i(st[3]), .enabled_i(st[4]), .shaft_held_i(st[5]),
    .brake_release_i(st[6]), .pos_limit_i(st[7]), .home_found_i(st[8]),
    .seg_reached_i(st[11:9]), .ms_tick_i, .pos_error_i, .velocity_i, .speed_error_i,
    .torque_i, .enc_index_i, .dout_o, .irq_o);
  sdo_relay_model #(.DLY(4)) u_relay (.clk_i, .coil_i(dout_o[0]), .contact_o(contact));

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Handshakes are judged at the falling edge, where ready is settled, and acted on next rise
  task automatic wr(input logic [11:0] a, input sdo_word_t d);
    logic aw, w, b;
    @(posedge clk_i);
    s_awaddr_i <= a;
    s_awvalid_i <= 1'b1;
    s_wdata_i <= d;
    s_wvalid_i <= 1'b1;
    s_bready_i <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk_i);
      aw = s_awvalid_i & s_awready_o;
      w = s_wvalid_i & s_wready_o;
      b = s_bvalid_o;
      rsp = s_bresp_o;
      @(posedge clk_i);
      if (aw) s_awvalid_i <= 1'b0;
      if (w) s_wvalid_i <= 1'b0;
    end
    s_bready_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    logic ar, r;
    @(posedge clk_i);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge clk_i);
      ar = s_arvalid_i & s_arready_o;
      r = s_rvalid_o;
      rdv = s_rdata_o;
      rsp = s_rresp_o;
      @(posedge clk_i);
      if (ar) s_arvalid_i <= 1'b0;
    end
    s_rready_i <= 1'b0;
  endtask : rd
  task automatic nap(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : nap
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i) ms_tick_i <= 1'b1;
      @(posedge clk_i) ms_tick_i <= 1'b0;
    end
  endtask : tick
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  // ********
  // Clock, timeout, sequence
  // ********
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // A hung handshake would stall the run, so cap it well above the expected length
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    {rst_n_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i} = '0;
    {ms_tick_i, enc_index_i, s_awaddr_i, s_araddr_i, st, s_wdata_i} = '0;
    {pos_error_i, velocity_i, speed_error_i, torque_i} = '0;
    s_wstrb_i = 4'hF;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    nap(1);
    chk(32'(dout_o), 0);
    chk(32'(irq_o), 0);
    rd(`SDO_A_POL);
    chk(rdv, 32'(`SDO_POL_RST));
    rd(`SDO_A_FSEL0);
    chk(rdv & 32'h0F0F_0F0F, 32'h0F0F_0F0F);
    $display("end of test: reset");
    wr(`SDO_A_POSWIN, 8); wr(`SDO_A_POSTIM, 0); wr(`SDO_A_ZVWIN, 10);
    wr(`SDO_A_ZVTIM, 0); wr(`SDO_A_SPWIN, 5); wr(`SDO_A_MAXSPD, 50);
    foreach (rows[i]) begin
      @(posedge clk_i);
      st <= rows[i].s;
      pos_error_i <= rows[i].pe;
      velocity_i <= rows[i].v;
      speed_error_i <= rows[i].se;
      wr(`SDO_A_FSEL0, 32'h0F0F_0F00 | 32'(rows[i].f));
      nap(4);
      chk(32'(dout_o), 32'(rows[i].x));
      rd(`SDO_A_EFF);
      chk(rdv & 32'h0000_00FF, 32'(rows[i].x));
      rd(`SDO_A_RAW);
      chk(rdv & 32'h0000_00FF, 32'(rows[i].x));
    end
    $display("end of test: function table");
    @(posedge clk_i) st <= 12'h001;
    wr(`SDO_A_FSEL0, 32'h0F0F_0F00);
    wr(`SDO_A_POL, 1);
    nap(3);
    chk(32'(dout_o), 0);
    rd(`SDO_A_EFF);
    chk(rdv & 32'h0000_0001, 1);
    rd(`SDO_A_RAW);
    chk(rdv & 32'h0000_0001, 0);
    @(posedge clk_i) st <= 12'h000;
    nap(3);
    chk(32'(dout_o), 1);
    wr(`SDO_A_POL, 0); wr(`SDO_A_SIMEN, 1); wr(`SDO_A_SIMVAL, 1);
    nap(3);
    chk(32'(dout_o), 1);
    wr(`SDO_A_SIMVAL, 0);
    @(posedge clk_i) st <= 12'h001;
    nap(3);
    chk(32'(dout_o), 0);
    wr(`SDO_A_SIMEN, 0);
    // Outputs 4 and 7 take ready through the second select word
    wr(`SDO_A_FSEL1, 32'h000F_0F00);
    nap(3);
    chk(32'(dout_o), 32'h0000_0091);
    wr(`SDO_A_FSEL1, 32'h0F0F_0F0F);
    $display("end of test: polarity and simulation");
    @(posedge clk_i) velocity_i <= 100;
    wr(`SDO_A_FSEL0, 32'h0F0F_0F03); wr(`SDO_A_ZVTIM, 3);
    @(posedge clk_i) velocity_i <= 0;
    tick(2); nap(3);
    chk(32'(dout_o), 0);
    tick(1); nap(3);
    chk(32'(dout_o), 1);
    @(posedge clk_i) torque_i <= 1000;
    wr(`SDO_A_FSEL0, 32'h0F0F_0F0E); wr(`SDO_A_TQREF, 0); wr(`SDO_A_TQTIM, 2);
    tick(5); nap(3);
    chk(32'(dout_o), 0);
    @(posedge clk_i) torque_i <= -100;
    wr(`SDO_A_TQREF, 100);
    tick(2); nap(3);
    chk(32'(dout_o), 0);
    tick(1); nap(3);
    chk(32'(dout_o), 1);
    $display("end of test: dwell timers");
    @(posedge clk_i) st <= 12'h000;
    wr(`SDO_A_FSEL0, 32'h0F0F_0F06); wr(`SDO_A_IRQMSK, 1); wr(`SDO_A_IRQST, 32'h0000_00FF);
    nap(2);
    chk(32'(irq_o), 0);
    hi = 0;
    @(posedge clk_i) enc_index_i <= 1'b1;
    repeat (12) begin
      @(negedge clk_i) hi += (dout_o[0] === 1'b1);
      @(posedge clk_i) enc_index_i <= 1'b0;
    end
    chk(hi, 1);
    chk(32'(irq_o), 1);
    wr(`SDO_A_IRQMSK, 0);
    nap(2);
    chk(32'(irq_o), 0);
    rd(`SDO_A_IRQST);
    chk(rdv & 32'h0000_0001, 1);
    wr(`SDO_A_IRQMSK, 1); wr(`SDO_A_IRQST, 1);
    nap(2);
    chk(32'(irq_o), 0);
    $display("end of test: index and interrupt");
    wr(`SDO_A_FSEL0, 32'h0F0F_0F04);
    @(posedge clk_i) st <= 12'h040;
    nap(10);
    chk(32'(contact), 1);
    @(posedge clk_i) st <= 12'h000;
    nap(5);
    chk(32'(contact), 0);
    rd(12'h0FC);
    chk(32'(rsp), 2);
    chk(rdv, 0);
    wr(12'h0FC, 32'h0000_0001);
    chk(32'(rsp), 2);
    $display("end of test: brake relay and unmapped");
    // Reset in mid-run must clear the pins and the polarity setting
    wr(`SDO_A_POL, 32'h0000_00A5);
    @(posedge clk_i) rst_n_i <= 1'b0;
    nap(2);
    chk(32'(dout_o), 0);
    chk(32'(irq_o), 0);
    @(posedge clk_i) rst_n_i <= 1'b1;
    nap(1);
    chk(32'(dout_o), 0);
    rd(`SDO_A_POL);
    chk(rdv, 32'(`SDO_POL_RST));
    $display("end of test: reset in mid-run");
    close_out();
  end
endmodule : servo_digital_output_mapping_tb
